//--- dual_slot_led_sequencer.sv
// Summary of operation
// [RULE1] every period runs slot A then slot B, each fully
// [RULE2] each slot keeps its own LED, front-end and result settings
// [RULE3] slot A active time is delay plus count times spacing
// [RULE4] slot B active time is delay plus count times spacing
// [RULE5] host keeps spacing at least twice integration window plus 11 us
// [RULE6] slot A compute interval of 68 us follows its pulses
// [RULE7] slot B compute interval of 20 us precedes sleep
// [RULE8] a disabled slot is skipped, pulses and compute both
// [RULE9] slot A first pulse delay in microseconds, low byte of slot_a_first_pulse_delay
// [RULE10] slot B first pulse delay in microseconds, low byte of slot_b_first_pulse_delay
// [RULE11] slot A pulse spacing in microseconds, low byte of slot_a_pulse_count_spacing
// [RULE12] slot B pulse spacing in microseconds, low byte of slot_b_pulse_count_spacing
// [RULE13] at least 222 us of sleep between periods
// [RULE14] host avoids delays below the minimum
// [RULE15] host avoids spacings below the minimum
// [RULE16] inputs form two groups of four sampled together
// [RULE17] each slot has its own readable result registers
// [RULE18] three LED drivers, each slot selects its own
// [RULE19] mode field: standby, program, normal; slots run only in normal
// [RULE20] pulse count 1 to 255, sample is sum of pulses
// [RULE21] periods started by a timer on a 32 kHz tick
// [RULE22] offsets, spacings and compute times count 1 us ticks
`timescale 1ns/1ps
`include "seq_defines.svh"
module dual_slot_led_sequencer (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [15:0]        reg_wdata,
	output logic      [15:0]        reg_rdata,
	input  wire logic               slot_a_en,
	input  wire logic               slot_b_en,
	input  wire logic [1:0]         slot_a_led_sel,
	input  wire logic [1:0]         slot_b_led_sel,
	input  wire logic               slot_a_pd_sel,
	input  wire logic               slot_b_pd_sel,
	input  wire seq_pkg::pd_sample_s photodiode_inputs,
	output logic      [2:0]         led_drive,
	output logic                    slot_a_done,
	output logic                    slot_b_done,
	output logic                    seq_busy
);
	// 9-bit compare so a full byte limit never wraps
	function automatic logic reached(input logic [7:0] cnt, input logic [7:0] lim);
		reached = ({1'b0, cnt} + 9'h001) >= {1'b0, lim};
	endfunction
	function automatic logic [2:0] led_hot(input logic [1:0] sel);
		led_hot = (sel == 2'h0) ? 3'h0 : 3'(3'h1 << (sel - 2'h1));
	endfunction
	// burst sums saturate rather than wrap at long counts
	function automatic seq_pkg::acc_t sat_add(input seq_pkg::acc_t a, input logic [13:0] b);
		logic [20:0] s;
		s = {1'b0, a} + {7'h00, b};
		sat_add = s[20] ? 20'hfffff : s[19:0];
	endfunction

	logic [5:0]             us_div_ff, nxt_us_div;
	logic [10:0]            t32_div_ff, nxt_t32_div;
	logic                   us_tick, tick32;
	logic [1:0]             mode_ff, nxt_mode;
	logic [15:0]            period_reg_ff, nxt_period_reg;
	logic [15:0]            dly_a_ff, nxt_dly_a, cnt_a_ff, nxt_cnt_a;
	logic [15:0]            dly_b_ff, nxt_dly_b, cnt_b_ff, nxt_cnt_b;
	seq_pkg::state_e        state_ff, nxt_state;
	logic [7:0]             phase_ff, nxt_phase, pulse_ff, nxt_pulse;
	logic [7:0]             sleep_ff, nxt_sleep;
	logic [15:0]            period_ff, nxt_period;
	logic                   pend_ff, nxt_pend;
	logic                   clr_a, clr_b, cap, fin_a, fin_b, in_b, normal;
	seq_pkg::slot_cfg_s     cfg_a, cfg_b, cur;
	logic [7:0]             eff_count;
	logic                   first_slot_led_strobe, second_slot_led_strobe;
	seq_pkg::acc_t          acc_ff [0:1][0:3];
	seq_pkg::acc_t          nxt_acc [0:1][0:3];
	seq_pkg::acc_t          res_ff [0:1][0:3];
	seq_pkg::acc_t          nxt_res [0:1][0:3];
	logic [15:0]            rdata_ff, nxt_rdata;
	logic [2:0]             led_ff, nxt_led;
	logic                   done_a_ff, done_b_ff;

	// 1 us and 32 kHz enables from the one system clock
	assign us_tick = (us_div_ff == 6'(`CYC_PER_US - 1));
	assign tick32 = (t32_div_ff == 11'(`CYC_PER_TICK32 - 1));
	always_comb
	begin
		nxt_us_div = us_tick ? 6'h00 : us_div_ff + 6'h01;
		nxt_t32_div = tick32 ? 11'h000 : t32_div_ff + 11'h001;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			us_div_ff <= 6'h00;
			t32_div_ff <= 11'h000;
		end
		else
		begin
			us_div_ff <= nxt_us_div;
			t32_div_ff <= nxt_t32_div;
		end
	end

	// register writes; slot timing only changes in program mode so a
	// running period never sees half-updated settings
	always_comb
	begin
		nxt_mode = mode_ff;
		nxt_period_reg = period_reg_ff;
		nxt_dly_a = dly_a_ff;
		nxt_cnt_a = cnt_a_ff;
		nxt_dly_b = dly_b_ff;
		nxt_cnt_b = cnt_b_ff;
		if (reg_wr)
		begin
			if (reg_addr == `ADDR_MODE)
				nxt_mode = reg_wdata[1:0];
			if (mode_ff == seq_pkg::MODE_PROGRAM)
			begin
				case (reg_addr)
					`ADDR_PERIOD: nxt_period_reg = reg_wdata;
					`ADDR_A_DELAY: nxt_dly_a = reg_wdata;
					`ADDR_A_CNT: nxt_cnt_a = reg_wdata;
					`ADDR_B_DELAY: nxt_dly_b = reg_wdata;
					`ADDR_B_CNT: nxt_cnt_b = reg_wdata;
					default: nxt_period_reg = period_reg_ff;
				endcase
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			mode_ff <= `RST_MODE;
			period_reg_ff <= `RST_PERIOD;
			dly_a_ff <= `RST_DELAY;
			cnt_a_ff <= `RST_CNT;
			dly_b_ff <= `RST_DELAY;
			cnt_b_ff <= `RST_CNT;
		end
		else
		begin
			mode_ff <= nxt_mode;
			period_reg_ff <= nxt_period_reg;
			dly_a_ff <= nxt_dly_a;
			cnt_a_ff <= nxt_cnt_a;
			dly_b_ff <= nxt_dly_b;
			cnt_b_ff <= nxt_cnt_b;
		end
	end

	// [RULE2] independent slot settings
	// [RULE9] [RULE10] [RULE11] [RULE12] delay and spacing fields
	assign cfg_a = '{dly_a_ff[`FLD_MSB:`FLD_LSB], cnt_a_ff[`CNT_MSB:`CNT_LSB],
		cnt_a_ff[`FLD_MSB:`FLD_LSB]};
	assign cfg_b = '{dly_b_ff[`FLD_MSB:`FLD_LSB], cnt_b_ff[`CNT_MSB:`CNT_LSB],
		cnt_b_ff[`FLD_MSB:`FLD_LSB]};
	assign in_b = (state_ff == seq_pkg::ST_B_OFF) || (state_ff == seq_pkg::ST_B_PUL)
		|| (state_ff == seq_pkg::ST_B_CMP);
	assign cur = in_b ? cfg_b : cfg_a;
	// [RULE20] zero count runs one pulse
	assign eff_count = (cur.pulse_count == 8'h00) ? 8'h01 : cur.pulse_count;
	assign normal = (mode_ff == seq_pkg::MODE_NORMAL);

	// sequencer: all phase timing advances on the 1 us enable only
	always_comb
	begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_pulse = pulse_ff;
		nxt_sleep = sleep_ff;
		nxt_period = period_ff;
		nxt_pend = pend_ff;
		clr_a = 1'b0;
		clr_b = 1'b0;
		cap = 1'b0;
		fin_a = 1'b0;
		fin_b = 1'b0;
		// [RULE19] sequencing only in normal mode
		if (!normal)
		begin
			nxt_state = seq_pkg::ST_SLEEP;
			nxt_phase = 8'h00;
			nxt_pulse = 8'h00;
			nxt_sleep = 8'h00;
			nxt_period = 16'h0000;
			nxt_pend = 1'b0;
		end
		else
		begin
			// [RULE22] microsecond tick stepping
			if (us_tick)
			begin
				nxt_phase = phase_ff + 8'h01;
				case (state_ff)
					seq_pkg::ST_SLEEP:
					begin
						nxt_phase = 8'h00;
						if (sleep_ff < 8'(`SLEEP_MIN_US))
							nxt_sleep = sleep_ff + 8'h01;
						// [RULE13] minimum sleep before start
						if (sleep_ff >= 8'(`SLEEP_MIN_US) && pend_ff && (slot_a_en || slot_b_en))
						begin
							nxt_pend = 1'b0;
							// [RULE8] skip a disabled slot
							nxt_state = slot_a_en ? seq_pkg::ST_A_OFF : seq_pkg::ST_B_OFF;
							clr_a = slot_a_en;
							clr_b = !slot_a_en;
						end
					end
					seq_pkg::ST_A_OFF, seq_pkg::ST_B_OFF:
					begin
						// [RULE9] [RULE10] first pulse delay
						if (reached(phase_ff, cur.pulse_delay))
						begin
							nxt_phase = 8'h00;
							nxt_state = in_b ? seq_pkg::ST_B_PUL : seq_pkg::ST_A_PUL;
						end
					end
					seq_pkg::ST_A_PUL, seq_pkg::ST_B_PUL:
					begin
						cap = (phase_ff == 8'(`LED_ON_US - 1));
						// [RULE3] [RULE4] count times spacing
						if (reached(phase_ff, cur.pulse_spacing))
						begin
							nxt_phase = 8'h00;
							nxt_pulse = pulse_ff + 8'h01;
							if (reached(pulse_ff, eff_count))
							begin
								nxt_pulse = 8'h00;
								nxt_state = in_b ? seq_pkg::ST_B_CMP : seq_pkg::ST_A_CMP;
							end
						end
					end
					seq_pkg::ST_A_CMP:
					begin
						// [RULE6] slot A compute time
						if (reached(phase_ff, 8'(`COMPUTE_A_US)))
						begin
							fin_a = 1'b1;
							nxt_phase = 8'h00;
							nxt_sleep = 8'h00;
							// [RULE1] slot B follows slot A
							nxt_state = slot_b_en ? seq_pkg::ST_B_OFF : seq_pkg::ST_SLEEP;
							clr_b = slot_b_en;
						end
					end
					seq_pkg::ST_B_CMP:
					begin
						// [RULE7] slot B compute time
						if (reached(phase_ff, 8'(`COMPUTE_B_US)))
						begin
							fin_b = 1'b1;
							nxt_phase = 8'h00;
							nxt_sleep = 8'h00;
							nxt_state = seq_pkg::ST_SLEEP;
						end
					end
					default: nxt_state = seq_pkg::ST_SLEEP;
				endcase
			end
			// [RULE21] sample timer, set wins over the start clear
			if (tick32)
			begin
				nxt_period = period_ff + 16'h0001;
				if ({1'b0, period_ff} + 17'h00001 >= {1'b0, period_reg_ff})
				begin
					nxt_period = 16'h0000;
					nxt_pend = 1'b1;
				end
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_ff <= seq_pkg::ST_SLEEP;
			phase_ff <= 8'h00;
			pulse_ff <= 8'h00;
			sleep_ff <= 8'h00;
			period_ff <= 16'h0000;
			pend_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			pulse_ff <= nxt_pulse;
			sleep_ff <= nxt_sleep;
			period_ff <= nxt_period;
			pend_ff <= nxt_pend;
		end
	end

	// LED strobes lead the integration window of each pulse
	assign first_slot_led_strobe = (state_ff == seq_pkg::ST_A_PUL) &&
		(phase_ff < 8'(`LED_ON_US));
	assign second_slot_led_strobe = (state_ff == seq_pkg::ST_B_PUL) &&
		(phase_ff < 8'(`LED_ON_US));

	// datapath: burst sums, results, LED drive and read data
	always_comb
	begin
		nxt_acc = acc_ff;
		nxt_res = res_ff;
		nxt_rdata = rdata_ff;
		// [RULE18] per-slot driver select
		nxt_led = 3'h0;
		if (first_slot_led_strobe)
			nxt_led = led_hot(slot_a_led_sel);
		if (second_slot_led_strobe)
			nxt_led = led_hot(slot_b_led_sel);
		for (int c = 0; c < 4; c++)
		begin
			if (clr_a)
				nxt_acc[0][c] = 20'h00000;
			if (clr_b)
				nxt_acc[1][c] = 20'h00000;
			// [RULE16] four channels captured together
			// [RULE20] sample sums every pulse
			if (cap && !in_b)
				nxt_acc[0][c] = sat_add(acc_ff[0][c], slot_a_pd_sel ?
					photodiode_inputs.grp_hi[c] : photodiode_inputs.grp_lo[c]);
			if (cap && in_b)
				nxt_acc[1][c] = sat_add(acc_ff[1][c], slot_b_pd_sel ?
					photodiode_inputs.grp_hi[c] : photodiode_inputs.grp_lo[c]);
			// [RULE17] separate result storage
			if (fin_a)
				nxt_res[0][c] = acc_ff[0][c];
			if (fin_b)
				nxt_res[1][c] = acc_ff[1][c];
		end
		if (reg_rd)
		begin
			case (reg_addr)
				`ADDR_MODE: nxt_rdata = {14'h0000, mode_ff};
				`ADDR_PERIOD: nxt_rdata = period_reg_ff;
				`ADDR_A_DELAY: nxt_rdata = dly_a_ff;
				`ADDR_A_CNT: nxt_rdata = cnt_a_ff;
				`ADDR_B_DELAY: nxt_rdata = dly_b_ff;
				`ADDR_B_CNT: nxt_rdata = cnt_b_ff;
				default: nxt_rdata = 16'h0000;
			endcase
			// results clip to 16 bits when read
			if (reg_addr[7:3] == `ADDR_RES_WIN)
				nxt_rdata = (res_ff[reg_addr[2]][reg_addr[1:0]][19:16] != 4'h0) ? 16'hffff :
					res_ff[reg_addr[2]][reg_addr[1:0]][15:0];
		end
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int s = 0; s < 2; s++)
				for (int c = 0; c < 4; c++)
				begin
					acc_ff[s][c] <= 20'h00000;
					res_ff[s][c] <= 20'h00000;
				end
			rdata_ff <= 16'h0000;
			led_ff <= 3'h0;
			done_a_ff <= 1'b0;
			done_b_ff <= 1'b0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			res_ff <= nxt_res;
			rdata_ff <= nxt_rdata;
			led_ff <= nxt_led;
			done_a_ff <= fin_a;
			done_b_ff <= fin_b;
		end
	end
	assign reg_rdata = rdata_ff;
	assign led_drive = led_ff;
	assign slot_a_done = done_a_ff;
	assign slot_b_done = done_b_ff;
	assign seq_busy = (state_ff != seq_pkg::ST_SLEEP);

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_led_in_pulse;
		|led_drive |-> $past(state_ff) inside {seq_pkg::ST_A_PUL, seq_pkg::ST_B_PUL};
	endproperty
	a_led_in_pulse: assert property (p_led_in_pulse) else $error("led outside pulse"); // [RULE18]
	property p_mode_stop;
		!normal |=> state_ff == seq_pkg::ST_SLEEP;
	endproperty
	a_mode_stop: assert property (p_mode_stop) else $error("ran outside normal"); // [RULE19]
	property p_b_after_a;
		$rose(state_ff == seq_pkg::ST_B_OFF) |->
			$past(state_ff) == seq_pkg::ST_A_CMP || !$past(slot_a_en);
	endproperty
	a_b_after_a: assert property (p_b_after_a) else $error("slot b out of order"); // [RULE1]
	property p_sleep_min;
		state_ff == seq_pkg::ST_SLEEP ##1 state_ff != seq_pkg::ST_SLEEP |->
			$past(sleep_ff) >= 8'(`SLEEP_MIN_US);
	endproperty
	a_sleep_min: assert property (p_sleep_min) else $error("sleep too short"); // [RULE13]
	property p_skip_a;
		$rose(state_ff == seq_pkg::ST_A_OFF) |-> $past(slot_a_en);
	endproperty
	a_skip_a: assert property (p_skip_a) else $error("disabled slot a ran"); // [RULE8]
	property p_cmp_a;
		state_ff == seq_pkg::ST_A_CMP |-> phase_ff < 8'(`COMPUTE_A_US);
	endproperty
	a_cmp_a: assert property (p_cmp_a) else $error("slot a compute overran"); // [RULE6]
	property p_cmp_b;
		state_ff == seq_pkg::ST_B_CMP |-> phase_ff < 8'(`COMPUTE_B_US);
	endproperty
	a_cmp_b: assert property (p_cmp_b) else $error("slot b compute overran"); // [RULE7]
	property p_delay_a;
		state_ff == seq_pkg::ST_A_OFF ##1 state_ff == seq_pkg::ST_A_PUL |->
			$past(reached(phase_ff, cfg_a.pulse_delay));
	endproperty
	a_delay_a: assert property (p_delay_a) else $error("slot a delay short"); // [RULE9]
	property p_count_a;
		state_ff == seq_pkg::ST_A_PUL ##1 state_ff == seq_pkg::ST_A_CMP |->
			$past(reached(pulse_ff, eff_count));
	endproperty
	a_count_a: assert property (p_count_a) else $error("slot a pulse count"); // [RULE3]
	property p_us_tick;
		us_tick |=> !us_tick [*8];
	endproperty
	a_us_tick: assert property (p_us_tick) else $error("us tick too often"); // [RULE22]
	property p_tick32;
		tick32 |=> !tick32 [*8];
	endproperty
	a_tick32: assert property (p_tick32) else $error("32k tick too often"); // [RULE21]
endmodule // dual_slot_led_sequencer

//--- seq_defines.svh
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
`define CLK_HZ 40000000
`define CYC_PER_US (`CLK_HZ / 1000000)
`define TICK32_HZ 32000
`define CYC_PER_TICK32 (`CLK_HZ / `TICK32_HZ)
`define COMPUTE_A_US 68
`define COMPUTE_B_US 20
`define SLEEP_MIN_US 222
`define LED_ON_US 3
`define ADDR_MODE 8'h10
`define ADDR_PERIOD 8'h12
`define ADDR_A_DELAY 8'h30
`define ADDR_A_CNT 8'h31
`define ADDR_B_DELAY 8'h35
`define ADDR_B_CNT 8'h36
`define ADDR_RES_WIN 5'h0c
`define CNT_MSB 15
`define CNT_LSB 8
`define FLD_MSB 7
`define FLD_LSB 0
`define RST_MODE 2'h0
`define RST_PERIOD 16'h0008
`define RST_DELAY 16'h0020
`define RST_CNT 16'h0113
`endif

//--- seq_pkg.sv
package seq_pkg;
	typedef enum logic [2:0] {
		ST_SLEEP = 3'h0,
		ST_A_OFF = 3'h1,
		ST_A_PUL = 3'h3,
		ST_A_CMP = 3'h2,
		ST_B_OFF = 3'h6,
		ST_B_PUL = 3'h7,
		ST_B_CMP = 3'h5
	} state_e;
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'h0,
		MODE_PROGRAM = 2'h1,
		MODE_NORMAL  = 2'h2
	} mode_e;
	typedef struct packed {
		logic [7:0] pulse_delay;
		logic [7:0] pulse_count;
		logic [7:0] pulse_spacing;
	} slot_cfg_s;
	typedef struct packed {
		logic [3:0][13:0] grp_hi;
		logic [3:0][13:0] grp_lo;
	} pd_sample_s;
	typedef logic [19:0] acc_t;
endpackage

//--- pd_front_end.sv
`timescale 1ns/1ps
// far-side photodiode front end: steady codes while an LED is lit
module pd_front_end (
	input  wire logic           clk,
	input  wire logic [2:0]     led_drive,
	output seq_pkg::pd_sample_s photodiode_inputs
);
	logic [1:0]  hold_ff = 2'h0;
	logic [13:0] churn_ff = 14'h0;
	logic        live;

	// codes held two cycles past the LED, then churned so a late capture shows up
	always_ff @(posedge clk)
	begin
		hold_ff  <= (|led_drive) ? 2'h2 : hold_ff - 2'(hold_ff != 2'h0);
		churn_ff <= churn_ff + 14'h1;
	end

	// low group 0x100+ch, high group 0x2000+ch while live
	always_comb
	begin
		live = (|led_drive) || (hold_ff != 2'h0);
		for (int i = 0; i < 4; i++)
		begin
			photodiode_inputs.grp_lo[i] = live ? 14'h100 + 14'(i) : ~churn_ff;
			photodiode_inputs.grp_hi[i] = live ? 14'h2000 + 14'(i) : churn_ff;
		end
	end
endmodule // pd_front_end

//--- dual_slot_led_sequencer_bench.sv
`timescale 1ns/1ps
`include "seq_defines.svh"
module dual_slot_led_sequencer_bench;
	logic                clk;
	logic                srst;
	logic                reg_wr;
	logic                reg_rd;
	logic [7:0]          reg_addr;
	logic [15:0]         reg_wdata;
	logic [15:0]         reg_rdata;
	logic                a_en;
	logic                b_en;
	logic [1:0]          a_led;
	logic [1:0]          b_led;
	logic                a_pd;
	logic                b_pd;
	seq_pkg::pd_sample_s pd_in;
	logic [2:0]          led_drive;
	logic                slot_a_done;
	logic                slot_b_done;
	logic                seq_busy;
	logic                busy_q = 1'b0;
	logic [2:0]          led_q = 3'h0;
	int                  error_cnt = 0;
	int                  checks = 0;
	int                  cyc = 0;
	int                  n_start = 0;
	int                  t_start;
	int                  t_end;
	int                  t_done_a = 0;
	int                  t_done_b;
	int                  led_cnt[3];
	int                  led_t1[3];
	int                  led_t2[3];

	dual_slot_led_sequencer dual_slot_led_sequencer_i (
		.clk               (clk),
		.srst              (srst),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_rdata         (reg_rdata),
		.slot_a_en         (a_en),
		.slot_b_en         (b_en),
		.slot_a_led_sel    (a_led),
		.slot_b_led_sel    (b_led),
		.slot_a_pd_sel     (a_pd),
		.slot_b_pd_sel     (b_pd),
		.photodiode_inputs (pd_in),
		.led_drive         (led_drive),
		.slot_a_done       (slot_a_done),
		.slot_b_done       (slot_b_done),
		.seq_busy          (seq_busy)
	);

	pd_front_end pd_front_end_i (
		.clk               (clk),
		.led_drive         (led_drive),
		.photodiode_inputs (pd_in)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// event timestamps, taken mid-cycle where outputs have settled
	always @(negedge clk)
	begin
		cyc++;
		if (seq_busy && !busy_q)
		begin
			t_start = cyc;
			n_start++;
			led_cnt = '{0, 0, 0};
		end
		if (!seq_busy && busy_q)
			t_end = cyc;
		for (int b = 0; b < 3; b++)
			if (led_drive[b] && !led_q[b])
			begin
				led_cnt[b]++;
				if (led_cnt[b] == 1)
					led_t1[b] = cyc;
				if (led_cnt[b] == 2)
					led_t2[b] = cyc;
			end
		if (slot_a_done)
			t_done_a = cyc;
		if (slot_b_done)
			t_done_b = cyc;
		busy_q = seq_busy;
		led_q = led_drive;
	end

	task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// rounds a cycle span to whole microseconds
	function automatic int us(input int c);
		return (c + `CYC_PER_US / 2) / `CYC_PER_US;
	endfunction

	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_check(input logic [7:0] a, input logic [15:0] e, input string what);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		cmp(what, {16'h0, reg_rdata}, {16'h0, e});
	endtask

	// bounded wait for the busy level; an overrun counts as a mismatch
	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (seq_busy !== lvl && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= lim)
			cmp("busy wait", 32'h0, 32'h1);
		@(posedge clk);
	endtask

	task automatic configure(input logic [7:0] da, na, sa, db, nb, sb, input logic [15:0] per);
		reg_write(`ADDR_MODE, 16'h0001);
		reg_write(`ADDR_PERIOD, per);
		reg_write(`ADDR_A_DELAY, {8'h00, da});
		reg_write(`ADDR_A_CNT, {na, sa});
		reg_write(`ADDR_B_DELAY, {8'h00, db});
		reg_write(`ADDR_B_CNT, {nb, sb});
		reg_write(`ADDR_MODE, 16'h0002);
	endtask

	// reset values, locked A delay register, unmapped read, idle standby
	task automatic regs_scenario();
		reg_check(`ADDR_MODE, 16'h0000, "mode");
		reg_check(`ADDR_PERIOD, 16'h0008, "period");
		reg_check(`ADDR_A_DELAY, 16'h0020, "a delay");
		reg_check(`ADDR_A_CNT, 16'h0113, "a count");
		reg_check(`ADDR_B_DELAY, 16'h0020, "b delay");
		reg_check(`ADDR_B_CNT, 16'h0113, "b count");
		reg_write(`ADDR_A_DELAY, 16'h0017);
		reg_check(`ADDR_A_DELAY, 16'h0020, "a delay locked");
		reg_check(8'h20, 16'h0000, "unmapped");
		repeat (10500) @(posedge clk);
		cmp("standby starts", n_start, 0);
	endtask

	// both slots, distinct drivers and groups
	task automatic two_slot_scenario();
		a_en  <= 1'b1;
		b_en  <= 1'b1;
		a_led <= 2'h1;
		b_led <= 2'h3;
		a_pd  <= 1'b0;
		b_pd  <= 1'b1;
		configure(8'd23, 8'd2, 8'd19, 8'd30, 8'd3, 8'd20, 16'h0008);
		wait_busy(1'b1, 12000);
		wait_busy(1'b0, 12000);
		cmp("a first pulse", us(led_t1[0] - t_start), 23);
		cmp("a spacing", us(led_t2[0] - led_t1[0]), 19);
		cmp("a pulses", led_cnt[0], 2);
		cmp("a slot", us(t_done_a - t_start), 23 + 2 * 19 + 68);
		cmp("b first pulse", us(led_t1[2] - t_done_a), 30);
		cmp("b spacing", us(led_t2[2] - led_t1[2]), 20);
		cmp("b pulses", led_cnt[2], 3);
		cmp("idle driver", led_cnt[1], 0);
		cmp("b slot", us(t_done_b - t_done_a), 30 + 3 * 20 + 20);
		cmp("b ends period", us(t_end - t_done_b), 0);
		for (int i = 0; i < 4; i++)
		begin
			reg_check(8'h60 + 8'(i), 16'(2 * (32'h100 + i)), "a result");
			reg_check(8'h64 + 8'(i), 16'(3 * (32'h2000 + i)), "b result");
		end
		wait_busy(1'b1, 12000);
		cmp("sleep", us(t_start - t_end) inside {[222:223]}, 1);
	endtask

	// slot A off: B alone, period from the timer, then an abort
	task automatic skip_scenario();
		int old_a;
		int t0;
		a_en  <= 1'b0;
		b_led <= 2'h2;
		b_pd  <= 1'b0;
		configure(8'd23, 8'd2, 8'd19, 8'd23, 8'd1, 8'd19, 16'h000c);
		old_a = t_done_a;
		wait_busy(1'b1, 16000);
		wait_busy(1'b0, 4000);
		cmp("a skipped", t_done_a, old_a);
		cmp("a driver", led_cnt[0], 0);
		cmp("b first pulse", us(led_t1[1] - t_start), 23);
		cmp("b slot", us(t_done_b - t_start), 23 + 19 + 20);
		for (int i = 0; i < 4; i++)
			reg_check(8'h64 + 8'(i), 16'(32'h100 + i), "b result lo");
		t0 = t_start;
		wait_busy(1'b1, 16000);
		cmp("period", us(t_start - t0) inside {[374:376]}, 1);
		reg_write(`ADDR_MODE, 16'h0000);
		repeat (3) @(negedge clk);
		cmp("abort busy", {31'h0, seq_busy}, 32'h0);
		cmp("abort leds", {29'h0, led_drive}, 32'h0);
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// watchdog sized above the three scenarios together
	initial
	begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		complete_run();
	end

	initial
	begin
		srst      = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 16'h0000;
		a_en      = 1'b0;
		b_en      = 1'b0;
		a_led     = 2'h0;
		b_led     = 2'h0;
		a_pd      = 1'b0;
		b_pd      = 1'b0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		regs_scenario();
		two_slot_scenario();
		skip_scenario();
		complete_run();
	end
endmodule // dual_slot_led_sequencer_bench
